//--- core/sipd_core.sv
// status, sticky alarm, interrupt pin and power-down logic with an axi4-lite register slave
`timescale 1ns/1ps

module sipd_core
   import sipd_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              clk_en,
   input  wire sipd_cond_t        cond,
   input  wire logic [1:0]        status_pin_in,
   output logic [1:0]             status_pin_out,
   output logic [1:0]             status_pin_oe_n,
   output sipd_pwr_t              pwr,
   output logic                   irq_level,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   // ======================================================================
   // configuration state
   logic [FUNC_W-1:0]   pin0_fn;
   logic [FUNC_W-1:0]   pin1_fn;
   logic                status_pin_invert;
   logic [1:0]          strap_level;
   sipd_mode_t          ref_mode;
   logic [NUM_SRC-1:0]  sticky;
   logic [NUM_SRC-1:0]  irq_en;
   logic [NUM_CH-1:0]   channel_power_down;
   logic [NUM_OUT-1:0]  output_power_down;
   logic [NUM_OUT-1:0]  output_refpath_power_down;
   logic [NUM_IN-1:0]   input_disable;
   logic                osc_buffer_power_down;
   logic                fb_div1_power_down;
   logic                rst_d;

   // bus state
   logic                aw_held;
   logic                w_held;
   logic [7:0]          aw_addr;
   logic [31:0]         w_data;
   logic [3:0]          w_strb;
   logic                wr_fire;
   logic                ar_fire;

   // ======================================================================
   // live status
   logic [NUM_IN-1:0]   input_live;
   logic                loop0_ref_valid_now;
   logic [NUM_SRC-1:0]  fault_now;
   logic [31:0]         status_word;

   always_comb
   begin
      input_live = cond.input_active & ~input_disable;
      case (ref_mode)
         SIPD_MODE_MANUAL:
            loop0_ref_valid_now = input_live[cond.manual_sel];
         SIPD_MODE_AUTO:
            loop0_ref_valid_now = |input_live;
         SIPD_MODE_SHORT_HO, SIPD_MODE_AUTO_HO:
            loop0_ref_valid_now = ~(~(|input_live) & cond.loop0_holdover);
         default:
            loop0_ref_valid_now = 1'b1;
      endcase
   end

   always_comb
   begin
      fault_now            = '0;
      fault_now[SRC_IN0]   = ~input_live[0];
      fault_now[SRC_IN1]   = ~input_live[1];
      fault_now[SRC_LOCK0] = ~cond.loop0_locked;
      fault_now[SRC_LOCK1] = ~cond.loop1_locked;
      fault_now[SRC_HOLD]  = cond.loop0_holdover;
      fault_now[SRC_REF]   = ~loop0_ref_valid_now;
   end

   // momentary view: no storage, read straight from the live terms
   always_comb
   begin
      status_word              = '0;
      status_word[SRC_IN0]     = input_live[0];
      status_word[SRC_IN1]     = input_live[1];
      status_word[SRC_LOCK0]   = cond.loop0_locked;
      status_word[SRC_LOCK1]   = cond.loop1_locked;
      status_word[SRC_HOLD]    = ~cond.loop0_holdover;
      status_word[SRC_REF]     = loop0_ref_valid_now;
      status_word[POS_DIVSYNC] = cond.divider_sync_busy;
   end

   // ======================================================================
   // axi4-lite write channel
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= '0;
         w_data       <= '0;
         w_strb       <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[1:0] == 2'b00 && aw_addr[7:2] <= ADDR_PWR_MISC[7:2])
                            ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ======================================================================
   // pin config; strap sampled one edge after reset release
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         rst_d <= 1'b1;
      else if (clk_en)
         rst_d <= 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pin0_fn           <= PIN0_DEFAULT;
         pin1_fn           <= PIN1_DEFAULT;
         status_pin_invert <= 1'b0;
         strap_level       <= '0;
         ref_mode          <= SIPD_MODE_MANUAL;
      end
      else if (clk_en)
      begin
         if (rst_d)
         begin
            strap_level <= status_pin_in;
            ref_mode    <= sipd_mode_t'(status_pin_in);
         end
         else if (wr_fire && aw_addr == ADDR_PIN_CFG)
         begin
            if (w_strb[0])
            begin
               pin0_fn <= w_data[POS_PIN0_FN +: FUNC_W];
               pin1_fn <= w_data[POS_PIN1_FN +: FUNC_W];
            end
            if (w_strb[1])
            begin
               status_pin_invert <= w_data[POS_INVERT];
               ref_mode          <= sipd_mode_t'(w_data[POS_INVERT+1 +: 2]);
            end
         end
      end
   end

   // ======================================================================
   // sticky alarms: the live fault is or-ed in after the clear
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         sticky <= '0;
      else if (clk_en)
      begin
         if (wr_fire && aw_addr == ADDR_STICKY && w_strb[0])
            sticky <= (sticky & ~w_data[NUM_SRC-1:0]) | fault_now;
         else
            sticky <= sticky | fault_now;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         irq_en <= '0;
      else if (clk_en && wr_fire && aw_addr == ADDR_IRQ_EN && w_strb[0])
         irq_en <= w_data[NUM_SRC-1:0];
   end

   // ======================================================================
   // power-down controls
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         channel_power_down        <= '0;
         output_power_down         <= '0;
         output_refpath_power_down <= '0;
         input_disable             <= '0;
         osc_buffer_power_down     <= 1'b0;
         fb_div1_power_down        <= 1'b0;
      end
      else if (clk_en && wr_fire)
      begin
         if (aw_addr == ADDR_PWR_CH && w_strb[0])
            channel_power_down <= w_data[NUM_CH-1:0];
         if (aw_addr == ADDR_PWR_OUT)
         begin
            if (w_strb[0]) output_power_down[7:0]  <= w_data[7:0];
            if (w_strb[1]) output_power_down[15:8] <= w_data[15:8];
         end
         if (aw_addr == ADDR_PWR_REF)
         begin
            if (w_strb[0]) output_refpath_power_down[7:0]  <= w_data[7:0];
            if (w_strb[1]) output_refpath_power_down[15:8] <= w_data[15:8];
         end
         if (aw_addr == ADDR_PWR_MISC && w_strb[0])
         begin
            osc_buffer_power_down <= w_data[POS_OSC_PD];
            fb_div1_power_down    <= w_data[POS_FB1_PD];
            input_disable         <= w_data[POS_IN_DIS +: NUM_IN];
         end
      end
   end

   // two outputs per channel; channel bit overrides both per-output bits
   always_comb
   begin
      for (int i = 0; i < NUM_OUT; i++)
      begin
         pwr.out_off[i]     = output_power_down[i] | channel_power_down[i/2];
         pwr.refpath_off[i] = output_refpath_power_down[i] | channel_power_down[i/2];
      end
      pwr.chan_off       = channel_power_down;
      pwr.input_off      = input_disable;
      pwr.osc_buffer_off = osc_buffer_power_down;
      pwr.fb_div1_off    = fb_div1_power_down;
   end

   // ======================================================================
   // interrupt and status pins
   assign irq_level = |(sticky & irq_en);

   function automatic logic [1:0] pin_drive(input logic [FUNC_W-1:0] fn);
      logic [1:0] r;
      r = 2'b10;
      case (fn)
         FN_LOCK0:     r = {1'b1, cond.loop0_locked};
         FN_LOCK1:     r = {1'b1, cond.loop1_locked};
         FN_LOCK_BOTH: r = {1'b1, cond.loop0_locked & cond.loop1_locked};
         FN_ACT_ALARM: r = {1'b1, ~(|(sticky[SRC_IN1:SRC_IN0] & ~input_disable))};
         FN_HOLDOVER:  r = {1'b1, ~cond.loop0_holdover};
         FN_IRQ:       r = {1'b1, irq_level};
         default:      r = 2'b00;
      endcase
      return r;
   endfunction

   logic [1:0] pin0_drive;
   logic [1:0] pin1_drive;

   always_comb
   begin
      pin0_drive = pin_drive(pin0_fn);
      pin1_drive = pin_drive(pin1_fn);
   end

   // pins are registered; inputs (non-output codes) stay undriven
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         status_pin_out  <= '0;
         status_pin_oe_n <= 2'b11;
      end
      else if (clk_en)
      begin
         status_pin_out  <= {pin1_drive[0], pin0_drive[0]} ^ {2{status_pin_invert}};
         status_pin_oe_n <= ~{pin1_drive[1], pin0_drive[1]};
      end
   end

   // ======================================================================
   // axi4-lite read channel, one cycle latency
   assign s_axi_arready = ~s_axi_rvalid;
   assign ar_fire       = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (clk_en)
      begin
         if (ar_fire)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            case (s_axi_araddr)
               ADDR_PIN_CFG:  s_axi_rdata <= {18'h0, strap_level, 1'b0, ref_mode,
                                             status_pin_invert, pin1_fn, pin0_fn};
               ADDR_STATUS:   s_axi_rdata <= status_word;
               ADDR_STICKY:   s_axi_rdata <= {26'h0, sticky};
               ADDR_IRQ_EN:   s_axi_rdata <= {26'h0, irq_en};
               ADDR_PWR_CH:   s_axi_rdata <= {24'h0, channel_power_down};
               ADDR_PWR_OUT:  s_axi_rdata <= {16'h0, output_power_down};
               ADDR_PWR_REF:  s_axi_rdata <= {16'h0, output_refpath_power_down};
               ADDR_PWR_MISC: s_axi_rdata <= {26'h0, input_disable, 2'b00,
                                             fb_div1_power_down, osc_buffer_power_down};
               default:
               begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

endmodule

//--- core/sipd_pkg.sv
// package: register map, field layout and defaults of the status, interrupt and power-down block
package sipd_pkg;

   // ======================================================================
   // register byte offsets
   localparam logic [7:0] ADDR_PIN_CFG   = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_STICKY    = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h0c;
   localparam logic [7:0] ADDR_PWR_CH    = 8'h10;
   localparam logic [7:0] ADDR_PWR_OUT   = 8'h14;
   localparam logic [7:0] ADDR_PWR_REF   = 8'h18;
   localparam logic [7:0] ADDR_PWR_MISC  = 8'h1c;

   // ======================================================================
   // sizes
   localparam int NUM_CH      = 8;
   localparam int NUM_OUT     = 16;
   localparam int NUM_IN      = 2;
   localparam int NUM_SRC     = 6;
   localparam int FUNC_W      = 4;

   // ======================================================================
   // pin function codes
   localparam logic [3:0] FN_LOCK0      = 4'h8;
   localparam logic [3:0] FN_LOCK1      = 4'h9;
   localparam logic [3:0] FN_LOCK_BOTH  = 4'ha;
   localparam logic [3:0] FN_ACT_ALARM  = 4'hb;
   localparam logic [3:0] FN_HOLDOVER   = 4'hc;
   localparam logic [3:0] FN_IRQ        = 4'hd;
   localparam logic [3:0] PIN0_DEFAULT  = FN_ACT_ALARM;
   localparam logic [3:0] PIN1_DEFAULT  = FN_LOCK_BOTH;

   // ======================================================================
   // field positions: pin config word
   localparam int POS_PIN0_FN   = 0;
   localparam int POS_PIN1_FN   = 4;
   localparam int POS_INVERT    = 8;
   localparam int POS_STRAP     = 12;
   // sticky / enable / status bit order
   localparam int SRC_IN0       = 0;
   localparam int SRC_IN1       = 1;
   localparam int SRC_LOCK0     = 2;
   localparam int SRC_LOCK1     = 3;
   localparam int SRC_HOLD      = 4;
   localparam int SRC_REF       = 5;
   localparam int POS_DIVSYNC   = 6;
   // misc power word
   localparam int POS_OSC_PD    = 0;
   localparam int POS_FB1_PD    = 1;
   localparam int POS_IN_DIS    = 4;

   // ======================================================================
   // reference select modes
   typedef enum logic [1:0] {
      SIPD_MODE_MANUAL    = 2'b00,
      SIPD_MODE_AUTO      = 2'b01,
      SIPD_MODE_SHORT_HO  = 2'b10,
      SIPD_MODE_AUTO_HO   = 2'b11
   } sipd_mode_t;

   // live conditions from the clock core
   typedef struct packed {
      logic [NUM_IN-1:0] input_active;
      logic              loop0_locked;
      logic              loop1_locked;
      logic              loop0_holdover;
      logic              divider_sync_busy;
      logic              manual_sel;
   } sipd_cond_t;

   // power-down enables toward the analog blocks
   typedef struct packed {
      logic [NUM_OUT-1:0] out_off;
      logic [NUM_OUT-1:0] refpath_off;
      logic [NUM_CH-1:0]  chan_off;
      logic [NUM_IN-1:0]  input_off;
      logic               osc_buffer_off;
      logic               fb_div1_off;
   } sipd_pwr_t;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

//--- tb/sipd_core_checker.sv
// checker: handshake, interrupt and power-down relations at the sipd_core ports
`timescale 1ns/1ps

module sipd_core_checker
   import sipd_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        clk_en,
   input wire sipd_pwr_t   pwr,
   input wire logic        irq_level,
   input wire logic [1:0]  status_pin_oe_n,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ======================================================================
   // helpers: channel bit spread onto its two outputs
   logic [NUM_OUT-1:0] chan_span;
   always_comb
   begin
      for (int i = 0; i < NUM_OUT; i++)
         chan_span[i] = pwr.chan_off[i/2];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // ======================================================================
   // assertions
   a_chan_override: assert property (((pwr.out_off & chan_span) == chan_span) && ((pwr.refpath_off & chan_span) == chan_span))
      else $error("channel power-down leaves an output powered");
   a_irq_fall_write: assert property ($fell(irq_level) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("interrupt released without a register write");
   a_pins_default: assert property ($fell(rst) |-> ##[1:3] (status_pin_oe_n == 2'b00))
      else $error("status pins not driving after reset");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before accepted");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before accepted");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en) ##1 clk_en
      |=> s_axi_bvalid)
      else $error("write answer late");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
endmodule

//--- tb/sipd_core_tb_top.sv
// testbench: register bus, status, sticky alarm, interrupt pin and power-down checks of sipd_core
`timescale 1ns/1ps

module sipd_core_tb_top
   import sipd_pkg::*;
;
   localparam sipd_cond_t GOOD = 7'b1111000;
   logic        sys_clk = 1'b0;
   logic        rst, clk_en, irq_level;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, en, inv;
   logic [1:0]  status_pin_in, status_pin_out, status_pin_oe_n, s_axi_bresp, s_axi_rresp, resp, mode, dis;
   logic [3:0]  s_axi_wstrb;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, ch;
   logic [15:0] po, pr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, bit_s;
   sipd_cond_t  cond;
   sipd_pwr_t   pwr;
   integer      seed = 60;
   int          errors = 0;
   int          check_count = 0;

   sipd_core u_sipd_core (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .cond(cond),
      .status_pin_in(status_pin_in), .status_pin_out(status_pin_out), .status_pin_oe_n(status_pin_oe_n),
      .pwr(pwr), .irq_level(irq_level), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   always #4 sys_clk = ~sys_clk;

   // ======================================================================
   // reporting
   task automatic tally_and_finish;
      $display("mismatches %0d, comparisons %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // ======================================================================
   // bus master: readies sampled at the falling edge, i.e. what the next rising edge sees
   task automatic bus_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_hit, w_hit, b_hit;
      int   n;
      @(posedge sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b_hit = 1'b0;
      n = 0;
      while (!b_hit)
      begin
         @(negedge sys_clk);
         aw_hit = (s_axi_awvalid && s_axi_awready) === 1'b1;
         w_hit = (s_axi_wvalid && s_axi_wready) === 1'b1;
         b_hit = s_axi_bvalid === 1'b1;
         r = s_axi_bresp;
         @(posedge sys_clk);
         if (aw_hit)
            s_axi_awvalid <= 1'b0;
         if (w_hit)
            s_axi_wvalid <= 1'b0;
         n++;
         if (n > 50)
         begin
            errors++;
            $display("Error at %0t: write never answered", $time);
            tally_and_finish();
         end
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ar_hit, r_hit;
      int   n;
      @(posedge sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r_hit = 1'b0;
      n = 0;
      while (!r_hit)
      begin
         @(negedge sys_clk);
         ar_hit = (s_axi_arvalid && s_axi_arready) === 1'b1;
         r_hit = s_axi_rvalid === 1'b1;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge sys_clk);
         if (ar_hit)
            s_axi_arvalid <= 1'b0;
         n++;
         if (n > 50)
         begin
            errors++;
            $display("Error at %0t: read never answered", $time);
            tally_and_finish();
         end
      end
      s_axi_rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      bus_write(a, d, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY}, "write response");
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string what);
      logic [31:0] d;
      logic [1:0]  r;
      bus_read(a, d, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY}, "read response");
      chk(d & m, e & m, what);
   endtask

   // ======================================================================
   // expectations
   function automatic logic [6:0] exp_status(input sipd_cond_t c, input logic [1:0] md, input logic [1:0] ds);
      logic [1:0] act;
      logic       rv;
      act = c.input_active & ~ds;
      case (md)
         2'b00:   rv = act[c.manual_sel];
         2'b01:   rv = |act;
         default: rv = (|act) || !c.loop0_holdover;
      endcase
      return {c.divider_sync_busy, rv, !c.loop0_holdover, c.loop1_locked, c.loop0_locked, act};
   endfunction

   function automatic sipd_cond_t fault(input int s);
      sipd_cond_t c;
      c = GOOD;
      case (s)
         0, 5:    c.input_active[0] = 1'b0;
         1:       c.input_active[1] = 1'b0;
         2:       c.loop0_locked = 1'b0;
         3:       c.loop1_locked = 1'b0;
         default: c.loop0_holdover = 1'b1;
      endcase
      return c;
   endfunction

   function automatic logic [15:0] span(input logic [7:0] c);
      for (int i = 0; i < 16; i++)
         span[i] = c[i/2];
   endfunction

   // ======================================================================
   // main sequence
   initial
   begin
      rst = 1'b1;
      clk_en = 1'b1;
      cond = GOOD;
      status_pin_in = 2'($random(seed));
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      s_axi_wstrb = 4'hf;
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd_chk(ADDR_PIN_CFG, 32'h37ff, {18'h0, status_pin_in, 1'b0, status_pin_in, 1'b0, 8'hab}, "pin cfg");
      chk({28'h0, status_pin_out, status_pin_oe_n}, 32'hc, "pins after reset");
      for (int a = 8; a <= 28; a += 4)
         rd_chk(8'(a), 32'hffffffff, 32'h0, "reset value");
      for (int k = 0; k < 24; k++)
      begin
         mode = k[1:0];
         dis = 2'($random(seed));
         wr(ADDR_PIN_CFG, {21'h0, mode, 1'b0, 8'hab});
         rd_chk(ADDR_PIN_CFG, 32'h7ff, {21'h0, mode, 1'b0, 8'hab}, "pin cfg rewritten");
         wr(ADDR_PWR_MISC, {26'h0, dis, 4'h0});
         @(posedge sys_clk);
         cond <= 7'($random(seed));
         repeat (2) @(posedge sys_clk);
         rd_chk(ADDR_STATUS, 32'h7f, {25'h0, exp_status(cond, mode, dis)}, "status");
         chk({30'h0, pwr.input_off}, {30'h0, dis}, "input disable");
      end
      // each source twice: first unmasked, then masked; invert alternates
      wr(ADDR_PWR_MISC, 32'h0);
      for (int k = 0; k < 12; k++)
      begin
         en = (k < 6);
         inv = k[0];
         bit_s = 32'h1 << (k % 6);
         @(posedge sys_clk);
         cond <= GOOD;
         wr(ADDR_PIN_CFG, {23'h0, inv, 8'had});
         wr(ADDR_IRQ_EN, en ? bit_s : 32'h0);
         wr(ADDR_STICKY, 32'h3f);
         rd_chk(ADDR_STICKY, 32'h3f, 32'h0, "sticky cleared");
         @(posedge sys_clk);
         cond <= fault(k % 6);
         repeat (3) @(posedge sys_clk);
         wr(ADDR_STICKY, bit_s);
         rd_chk(ADDR_STICKY, bit_s, bit_s, "sticky set again");
         @(posedge sys_clk);
         cond <= GOOD;
         repeat (3) @(posedge sys_clk);
         wr(ADDR_STICKY, 32'h0);
         rd_chk(ADDR_STICKY, bit_s, bit_s, "sticky holds");
         chk({27'h0, irq_level, status_pin_out, status_pin_oe_n}, {27'h0, en, ~inv, en ^ inv, 2'b00}, "irq");
         wr(ADDR_STICKY, bit_s);
         rd_chk(ADDR_STICKY, bit_s, 32'h0, "sticky cleared by one");
         chk({30'h0, irq_level, status_pin_out[0]}, {30'h0, 1'b0, inv}, "irq released");
      end
      for (int k = 0; k < 10; k++)
      begin
         ch = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
         po = 16'($random(seed));
         pr = 16'($random(seed));
         dis = 2'($random(seed));
         wr(ADDR_PWR_CH, {24'h0, ch});
         wr(ADDR_PWR_OUT, {16'h0, po});
         wr(ADDR_PWR_REF, {16'h0, pr});
         wr(ADDR_PWR_MISC, {30'h0, dis});
         chk({16'h0, pwr.out_off}, {16'h0, po | span(ch)}, "output off");
         chk({16'h0, pwr.refpath_off}, {16'h0, pr | span(ch)}, "refpath off");
         chk({22'h0, pwr.chan_off, pwr.fb_div1_off, pwr.osc_buffer_off}, {22'h0, ch, dis}, "misc off");
         rd_chk(ADDR_PWR_REF, 32'hffff, {16'h0, pr}, "refpath readback");
      end
      bus_read(8'h24, rd, resp);
      chk(rd, 32'h0, "unmapped read data");
      chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read");
      bus_write(8'h24, 32'hffffffff, resp);
      chk({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
      // frozen clock enable must hold off the alarm latch; leftover alarms cleared first
      wr(ADDR_STICKY, 32'h3f);
      wr(ADDR_IRQ_EN, 32'h3f);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      cond <= fault(2);
      repeat (3) @(posedge sys_clk);
      chk({31'h0, irq_level}, 32'h0, "frozen irq");
      clk_en <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk({31'h0, irq_level}, 32'h1, "irq after unfreeze");
      // remaining pin codes: not-holdover, lock1, lock0 and an undriven code
      wr(ADDR_PIN_CFG, 32'h9c);
      @(posedge sys_clk);
      chk({28'h0, status_pin_out, status_pin_oe_n}, 32'hc, "holdover and lock1 pins");
      wr(ADDR_PIN_CFG, 32'he8);
      @(posedge sys_clk);
      chk({28'h0, status_pin_out, status_pin_oe_n}, 32'h2, "lock0 pin, idle pin");
      tally_and_finish();
   end
endmodule

bind sipd_core sipd_core_checker u_sipd_core_checker (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .pwr(pwr),
   .irq_level(irq_level), .status_pin_oe_n(status_pin_oe_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
